// *** rcp_pkg.sv ***
/*
  Constants, field layout and types of the reference clock and PLL control block.
  Assumes a single 250 MHz register clock and a 32-bit AXI4-Lite register bus.
*/
// How it works
// RULE_01 - Three-bit input mode picks differential, crystal or CMOS source, PLL on or off
// RULE_02 - Mode field resets to differential input with PLL bypassed
// RULE_03 - Top mode bit set with mode bit 1 clear selects the single-ended CMOS reference input; bit 1 set selects crystal
// RULE_04 - PLL stays powered down after reset until software sets it up
// RULE_05 - Software clears power-down and sets the reset-release bit to start the PLL
// RULE_06 - PLL digital logic held in reset while the reset-release bit is zero
// RULE_07 - Power-down bit set powers the PLL down, cleared powers it up
// RULE_08 - Low-range bit adjusts the loop filter, only while the PLL is enabled
// RULE_09 - Input divide bit halves the reference ahead of the phase detector
// RULE_10 - Oscillator-select bit chooses one of two PLL oscillators
// RULE_11 - Output divider enable bit inserts a divider at the PLL output
// RULE_12 - Feedback divider is a divide-by-N stage then a divide-by-one-or-two stage
// RULE_13 - Overall multiplication factor spans a quarter to sixty-four times the reference
// RULE_14 - Bit zero of the config register shows PLL lock and is read-only
// RULE_15 - PLL selected but unlocked: system clock runs from the reference
// RULE_16 - Lock rising switches the system clock to the PLL output
// RULE_17 - Lock falling returns the system clock to the reference
// RULE_18 - Software keeps divider settings so the system clock stays at or below 250 MHz
// RULE_19 - Lock status passes two flip-flops before any register read sees it
package rcp_pkg;

  // Register byte offsets
  localparam logic [7:0] RCP_OFS_CONFIG = 8'h00;
  localparam logic [7:0] RCP_OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] RCP_OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] RCP_OFS_STATUS = 8'h0c;

  // Config register field positions
  localparam int RCP_LOCK_BIT = 0;
  localparam int RCP_RESET_N_BIT = 1;
  localparam int RCP_OSC_SEL_BIT = 2;
  localparam int RCP_IN_DIV2_BIT = 3;
  localparam int RCP_LOW_RANGE_BIT = 4;
  localparam int RCP_PWRDN_BIT = 5;
  localparam int RCP_MODE_LSB = 5;
  localparam int RCP_MODE_MSB = 7;
  localparam int RCP_FBN_LSB = 9;
  localparam int RCP_FBN_MSB = 13;
  localparam int RCP_FB_DIV2_BIT = 14;
  localparam int RCP_OUT_DIV_BIT = 15;

  // Reset values: mode 001, so the PLL is powered down and held in reset
  localparam logic [15:0] RCP_CONFIG_RESET = 16'h0020;
  localparam logic [1:0] RCP_IRQ_RESET = 2'h0;

  // Interrupt status bit positions
  localparam int RCP_IRQ_LOCK_GAINED = 0;
  localparam int RCP_IRQ_LOCK_LOST = 1;

  // Multiplier in quarter steps: 0.25x .. 64x
  localparam int RCP_MULT_W = 9;
  localparam logic [5:0] RCP_FBN_ZERO_AS = 6'h20;
  localparam int RCP_SYSTEM_CLOCK_MAX_MHZ = 250;

  // AXI answers
  localparam logic [1:0] RCP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RCP_SRC_DIFF = 2'b00,
    RCP_SRC_CRYSTAL_INPUT = 2'b01,
    RCP_SRC_CMOS = 2'b10
  } rcp_src_t;

  typedef enum logic [1:0] {
    RCP_SEL_REF = 2'b00,
    RCP_SEL_WAIT = 2'b01,
    RCP_SEL_PLL = 2'b10
  } rcp_sel_t;

endpackage

// *** rcp_sync2.sv ***
/*
  Two flip-flop level synchroniser for one bit.
  Assumes the input is a level from another clock domain or a pin.
*/
`timescale 1ns/1ns
module rcp_sync2
  import rcp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;
  logic sync_reg;

  // The first stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// *** rcp_ref_clock_pll_control.sv ***
/*
  Reference clock source and PLL control: config register, lock tracking,
  system clock source selection and lock interrupts behind an AXI4-Lite slave.
  Assumes PLL_LOCK arrives asynchronously from the analog PLL and that the
  clock multiplexer downstream acts on SYSTEM_CLOCK_FROM_PLL.
*/
`timescale 1ns/1ns
module rcp_ref_clock_pll_control
  import rcp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic PLL_LOCK,
  output logic [1:0] REF_SOURCE,
  output logic PLL_ENABLE,
  output logic PLL_PWRDN,
  output logic PLL_RESET_N,
  output logic PLL_LOW_RANGE,
  output logic PLL_IN_DIV2,
  output logic PLL_OSC_SEL,
  output logic PLL_OUT_DIV_EN,
  output logic [4:0] PLL_FB_DIV_N,
  output logic PLL_FB_DIV2,
  output logic [RCP_MULT_W-1:0] PLL_MULT_QTR,
  output logic SYSTEM_CLOCK_FROM_PLL,
  output logic IRQ
);

  // Mode decode: PLL on for 000, x10, 100
  function automatic logic mode_pll_on(input logic [2:0] mode);
    mode_pll_on = ~mode[0];
  endfunction

  // Mode decode: source select, bit 1 set means crystal regardless of bit 2
  function automatic rcp_src_t mode_source(input logic [2:0] mode);
    if (mode[1]) begin
      mode_source = RCP_SRC_CRYSTAL_INPUT;
    end else if (mode[2]) begin
      mode_source = RCP_SRC_CMOS;
    end else begin
      mode_source = RCP_SRC_DIFF;
    end
  endfunction

  logic lock_sync;
  logic lock_d_reg;
  logic [15:0] cfg_reg;
  logic [1:0] irq_sts_reg;
  logic [1:0] irq_sts_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  rcp_sel_t sel_reg;
  rcp_sel_t sel_next;
  logic [1:0] src_reg;
  logic pll_en_reg;
  logic pwrdn_reg;
  logic reset_n_reg;
  logic low_range_reg;
  logic in_div2_reg;
  logic osc_sel_reg;
  logic out_div_reg;
  logic [4:0] fbn_reg;
  logic fb_div2_reg;
  logic [RCP_MULT_W-1:0] mult_reg;
  logic from_pll_reg;
  logic irq_reg;

  // Lock crosses in from the analog PLL through two flip-flops
  rcp_sync2 u_lock_sync (
    .clk(CLK),
    .reset(RESET),
    .async_in(PLL_LOCK),
    .sync_out(lock_sync)
  ); // RULE_19

  // Bus handshakes and address decode
  wire aw_take = AWVALID & awready_reg;
  wire w_take = WVALID & wready_reg;
  wire wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire b_done = bvalid_reg & BREADY;
  wire ar_take = ARVALID & arready_reg;
  wire r_done = rvalid_reg & RREADY;
  wire [7:0] wofs = 8'(waddr_reg);
  wire [7:0] rofs = 8'(ARADDR);
  wire wr_cfg = wr_go & (wofs == RCP_OFS_CONFIG);
  wire wr_sts = wr_go & (wofs == RCP_OFS_IRQ_STATUS);
  wire wr_mask = wr_go & (wofs == RCP_OFS_IRQ_MASK);
  wire wr_hit = wr_cfg | wr_sts | wr_mask | (wofs == RCP_OFS_STATUS);
  wire rd_hit = (rofs == RCP_OFS_CONFIG) | (rofs == RCP_OFS_IRQ_STATUS) |
                (rofs == RCP_OFS_IRQ_MASK) | (rofs == RCP_OFS_STATUS);
  wire aw_held_next = (aw_held_reg | aw_take) & ~wr_go;
  wire w_held_next = (w_held_reg | w_take) & ~wr_go;
  wire bvalid_next = wr_go | (bvalid_reg & ~BREADY);
  wire rvalid_next = ar_take | (rvalid_reg & ~RREADY);

  // Config byte lanes; bit 0 is never stored, it always reads the lock
  wire [7:0] cfg_lo_next = (wr_cfg & wstrb_reg[0]) ? {wdata_reg[7:1], 1'b0} : cfg_reg[7:0]; // RULE_14
  wire [7:0] cfg_hi_next = (wr_cfg & wstrb_reg[1]) ? wdata_reg[15:8] : cfg_reg[15:8];
  wire [15:0] cfg_next = {cfg_hi_next, cfg_lo_next};
  wire [2:0] mode_w = cfg_reg[RCP_MODE_MSB:RCP_MODE_LSB];

  // PLL runs only once powered up and its digital reset is released
  wire pll_on_w = mode_pll_on(mode_w); // RULE_01
  wire pll_run_w = pll_on_w & cfg_reg[RCP_RESET_N_BIT]; // RULE_05

  // Multiplier in quarters: N (0 reads as 32) x fb stage / input div / output div
  wire [4:0] fbn_w = cfg_reg[RCP_FBN_MSB:RCP_FBN_LSB];
  wire [5:0] fbn_eff = (fbn_w == 5'h00) ? RCP_FBN_ZERO_AS : {1'b0, fbn_w}; // RULE_12
  wire [8:0] mult_base = {1'b0, fbn_eff, 2'b00};
  wire [8:0] mult_fb = cfg_reg[RCP_FB_DIV2_BIT] ? {mult_base[7:0], 1'b0} : mult_base; // RULE_12
  wire [1:0] mult_shr = {1'b0, cfg_reg[RCP_IN_DIV2_BIT]} + {1'b0, cfg_reg[RCP_OUT_DIV_BIT]};
  wire [8:0] mult_w = mult_fb >> mult_shr; // RULE_13

  // Lock edges; a set in the clearing cycle wins over the clear
  wire lock_rise = lock_sync & ~lock_d_reg;
  wire lock_fall = ~lock_sync & lock_d_reg;
  wire [1:0] sts_clr = wr_sts & wstrb_reg[0] ? wdata_reg[1:0] : 2'h0;
  wire [1:0] sts_set = {lock_fall, lock_rise};
  assign irq_sts_next = (irq_sts_reg & ~sts_clr) | sts_set;
  assign irq_mask_next = (wr_mask & wstrb_reg[0]) ? wdata_reg[1:0] : irq_mask_reg;

  // Read data selection
  wire [31:0] rd_w = (rofs == RCP_OFS_CONFIG) ? {16'h0000, cfg_reg[15:1], lock_sync} : // RULE_14
                     (rofs == RCP_OFS_IRQ_STATUS) ? {30'h0, irq_sts_reg} :
                     (rofs == RCP_OFS_IRQ_MASK) ? {30'h0, irq_mask_reg} :
                     (rofs == RCP_OFS_STATUS) ? {21'h0, mult_reg, from_pll_reg, lock_sync} : 32'h0;

  // Clock source tracking; the reference carries the system clock until lock
  always_comb begin
    case (sel_reg)
      RCP_SEL_REF: begin
        sel_next = pll_run_w ? (lock_sync ? RCP_SEL_PLL : RCP_SEL_WAIT) : RCP_SEL_REF;
      end
      RCP_SEL_WAIT: begin
        sel_next = !pll_run_w ? RCP_SEL_REF : (lock_sync ? RCP_SEL_PLL : RCP_SEL_WAIT); // RULE_15
      end
      RCP_SEL_PLL: begin
        sel_next = !pll_run_w ? RCP_SEL_REF : (lock_sync ? RCP_SEL_PLL : RCP_SEL_WAIT); // RULE_17
      end
      default: begin
        sel_next = RCP_SEL_REF;
      end
    endcase
  end

  // Write channel state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RCP_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= ~aw_held_next & ~bvalid_next;
      wready_reg <= ~w_held_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      if (wr_go) begin
        bresp_reg <= wr_hit ? RCP_RESP_OKAY : RCP_RESP_SLVERR;
      end
    end
  end

  // Write payload capture
  always_ff @(posedge CLK) begin
    if (RESET) begin
      waddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        waddr_reg <= AWADDR;
      end
      if (w_take) begin
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
    end
  end

  // Read channel; the answer is registered on the same edge that takes the address
  always_ff @(posedge CLK) begin
    if (RESET) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RCP_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_w;
        rresp_reg <= rd_hit ? RCP_RESP_OKAY : RCP_RESP_SLVERR;
      end
    end
  end

  // Registers that software sees; config comes up bypassed and powered down
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_reg <= RCP_CONFIG_RESET; // RULE_02
      irq_sts_reg <= RCP_IRQ_RESET;
      irq_mask_reg <= RCP_IRQ_RESET;
      lock_d_reg <= 1'b0;
      sel_reg <= RCP_SEL_REF;
    end else begin
      cfg_reg <= cfg_next;
      irq_sts_reg <= irq_sts_next;
      irq_mask_reg <= irq_mask_next;
      lock_d_reg <= lock_sync;
      sel_reg <= sel_next;
    end
  end

  // Control outputs to the analog clock path, one edge behind the register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_reg <= RCP_SRC_DIFF;
      pll_en_reg <= 1'b0;
      pwrdn_reg <= 1'b1; // RULE_04
      reset_n_reg <= 1'b0;
      low_range_reg <= 1'b0;
      in_div2_reg <= 1'b0;
      osc_sel_reg <= 1'b0;
      out_div_reg <= 1'b0;
      fbn_reg <= 5'h00;
      fb_div2_reg <= 1'b0;
      mult_reg <= '0;
      from_pll_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      src_reg <= mode_source(mode_w); // RULE_03
      pll_en_reg <= pll_on_w; // RULE_07
      pwrdn_reg <= cfg_reg[RCP_PWRDN_BIT]; // RULE_07
      reset_n_reg <= cfg_reg[RCP_RESET_N_BIT]; // RULE_06
      low_range_reg <= cfg_reg[RCP_LOW_RANGE_BIT] & pll_on_w; // RULE_08
      in_div2_reg <= cfg_reg[RCP_IN_DIV2_BIT]; // RULE_09
      osc_sel_reg <= cfg_reg[RCP_OSC_SEL_BIT]; // RULE_10
      out_div_reg <= cfg_reg[RCP_OUT_DIV_BIT]; // RULE_11
      fbn_reg <= fbn_w; // RULE_12
      fb_div2_reg <= cfg_reg[RCP_FB_DIV2_BIT]; // RULE_12
      mult_reg <= mult_w; // RULE_13
      from_pll_reg <= (sel_next == RCP_SEL_PLL); // RULE_16
      irq_reg <= |(irq_sts_next & irq_mask_next);
    end
  end

  assign AWREADY = awready_reg;
  assign WREADY = wready_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign ARREADY = arready_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;
  assign REF_SOURCE = src_reg;
  assign PLL_ENABLE = pll_en_reg;
  assign PLL_PWRDN = pwrdn_reg;
  assign PLL_RESET_N = reset_n_reg;
  assign PLL_LOW_RANGE = low_range_reg;
  assign PLL_IN_DIV2 = in_div2_reg;
  assign PLL_OSC_SEL = osc_sel_reg;
  assign PLL_OUT_DIV_EN = out_div_reg;
  assign PLL_FB_DIV_N = fbn_reg;
  assign PLL_FB_DIV2 = fb_div2_reg;
  assign PLL_MULT_QTR = mult_reg;
  assign SYSTEM_CLOCK_FROM_PLL = from_pll_reg;
  assign IRQ = irq_reg;

  // Checks on the control path
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_MODE_RESET: assert property ($fell(RESET) |-> cfg_reg[7:5] == 3'b001) // RULE_02
    else $error("Mode field not bypassed differential after reset");
  AST_CRYSTAL_INPUT_DECODE: assert property (cfg_reg[6:5] == 2'b10 |=> REF_SOURCE == RCP_SRC_CRYSTAL_INPUT && PLL_ENABLE) // RULE_01
    else $error("Crystal with PLL not decoded");
  AST_CMOS_SRC: assert property (cfg_reg[7:5] == 3'b101 |=> REF_SOURCE == RCP_SRC_CMOS && !PLL_ENABLE) // RULE_03
    else $error("CMOS source not selected");
  AST_PLL_HELD: assert property (!cfg_reg[RCP_RESET_N_BIT] |=> !PLL_RESET_N && !SYSTEM_CLOCK_FROM_PLL) // RULE_06
    else $error("PLL logic released while reset bit is zero");
  AST_PWRDN: assert property (cfg_reg[RCP_PWRDN_BIT] |=> PLL_PWRDN && !PLL_LOW_RANGE) // RULE_07
    else $error("PLL not powered down");
  AST_MULT_64: assert property (fbn_w == 5'h00 && cfg_reg[15:14] == 2'b01 && !cfg_reg[3] |=> PLL_MULT_QTR == 9'h100) // RULE_13
    else $error("Largest multiplier not 64x");
  AST_MULT_QUARTER: assert property (fbn_w == 5'h01 && cfg_reg[15:14] == 2'b10 && cfg_reg[3] |=> PLL_MULT_QTR == 9'h001) // RULE_13
    else $error("Smallest multiplier not 0.25x");
  AST_LOCK_READ: assert property (ar_take && rofs == RCP_OFS_CONFIG |=> RDATA[0] == $past(PLL_LOCK, 3)) // RULE_14
    else $error("Config bit zero does not show lock");
  AST_SYNC_DELAY: assert property (lock_sync == $past(PLL_LOCK, 2)) // RULE_19
    else $error("Lock not synchronised in two stages");
  AST_REF_UNLOCKED: assert property (!lock_sync |=> !SYSTEM_CLOCK_FROM_PLL) // RULE_15
    else $error("System clock on PLL without lock");
  AST_SWITCH_ON_LOCK: assert property (lock_sync && pll_run_w |=> SYSTEM_CLOCK_FROM_PLL) // RULE_16
    else $error("System clock did not follow lock");
  AST_LOSS_EVENT: assert property ($fell(lock_sync) |=> irq_sts_reg[RCP_IRQ_LOCK_LOST] && !SYSTEM_CLOCK_FROM_PLL) // RULE_17
    else $error("Lock loss not reported or not reverted");
  AST_IRQ_LEVEL: assert property (IRQ == |(irq_sts_reg & irq_mask_reg))
    else $error("Interrupt output disagrees with status and mask");

  COV_LOCK_GAINED: cover property (pll_run_w ##1 !lock_sync [*2] ##1 lock_sync ##1 SYSTEM_CLOCK_FROM_PLL);
  COV_LOCK_LOST: cover property (SYSTEM_CLOCK_FROM_PLL ##1 !lock_sync ##1 !SYSTEM_CLOCK_FROM_PLL);
  COV_SET_WINS: cover property (wr_sts && sts_clr[0] && lock_rise);
  COV_BAD_ADDR: cover property (bvalid_reg && bresp_reg == RCP_RESP_SLVERR);

endmodule

// *** rcp_pll_model.sv ***
/*
  Behavioural model of the analog PLL that answers the control block with a lock level.
  Assumes the block's PLL_PWRDN and PLL_RESET_N outputs and one shared clock.
*/
`timescale 1ns/1ns
module rcp_pll_model
(
  input wire logic clk,
  input wire logic pll_pwrdn,
  input wire logic pll_reset_n,
  input wire logic drop,
  input wire integer lock_dly,
  output logic pll_lock
);
  int cnt;

  initial pll_lock = 1'b0;

  // Lock only while powered and out of reset; drop forces loss of lock
  always @(posedge clk) begin
    if (pll_pwrdn || !pll_reset_n || drop) begin
      cnt <= 0;
      pll_lock <= 1'b0;
    end else if (cnt >= lock_dly) begin
      pll_lock <= 1'b1; // Delay set by bench, so lock can come fast or slow
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** testbench.sv ***
/*
  Self-checking bench of the reference clock and PLL control block.
  Assumes the PLL model beside it and AXI4-Lite stimulus from this module.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
  import rcp_pkg::*;
;
  logic CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY, drop;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, REF_SOURCE, r;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PLL_LOCK, PLL_ENABLE, PLL_PWRDN, PLL_RESET_N;
  logic PLL_LOW_RANGE, PLL_IN_DIV2, PLL_OSC_SEL, PLL_OUT_DIV_EN, PLL_FB_DIV2, SYSTEM_CLOCK_FROM_PLL, IRQ;
  logic [4:0] PLL_FB_DIV_N;
  logic [RCP_MULT_W-1:0] PLL_MULT_QTR;
  int fail_count, checks_done, cycles, lock_dly;

  rcp_ref_clock_pll_control #(.ADDR_W(8)) i_rcp_ref_clock_pll_control (.CLK(CLK), .RESET(RESET),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .PLL_LOCK(PLL_LOCK), .REF_SOURCE(REF_SOURCE),
    .PLL_ENABLE(PLL_ENABLE), .PLL_PWRDN(PLL_PWRDN), .PLL_RESET_N(PLL_RESET_N),
    .PLL_LOW_RANGE(PLL_LOW_RANGE), .PLL_IN_DIV2(PLL_IN_DIV2), .PLL_OSC_SEL(PLL_OSC_SEL),
    .PLL_OUT_DIV_EN(PLL_OUT_DIV_EN), .PLL_FB_DIV_N(PLL_FB_DIV_N), .PLL_FB_DIV2(PLL_FB_DIV2),
    .PLL_MULT_QTR(PLL_MULT_QTR), .SYSTEM_CLOCK_FROM_PLL(SYSTEM_CLOCK_FROM_PLL), .IRQ(IRQ));

  rcp_pll_model i_rcp_pll_model (.clk(CLK), .pll_pwrdn(PLL_PWRDN), .pll_reset_n(PLL_RESET_N),
    .drop(drop), .lock_dly(lock_dly), .pll_lock(PLL_LOCK));

  // 250 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // Hang guard: the whole run needs well under 5000 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw, w, ta, tw;
    aw = 1'b1;
    w = 1'b1;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (aw || w) begin
      @(negedge CLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      @(posedge CLK);
      if (ta) begin
        AWVALID <= 1'b0;
        aw = 1'b0;
      end
      if (tw) begin
        WVALID <= 1'b0;
        w = 1'b0;
      end
    end
    do @(negedge CLK); while (BVALID !== 1'b1);
    resp = BRESP;
    @(posedge CLK);
    BREADY <= 1'b0;
    @(negedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(negedge CLK); while (ARREADY !== 1'b1);
    @(posedge CLK);
    ARVALID <= 1'b0;
    do @(negedge CLK); while (RVALID !== 1'b1);
    v = RDATA;
    resp = RRESP;
    @(posedge CLK);
    RREADY <= 1'b0;
    @(negedge CLK);
  endtask

  // Bounded wait for the clock source flag to reach a level
  task automatic wait_sel(input logic v);
    int n;
    n = 0;
    while (SYSTEM_CLOCK_FROM_PLL !== v && n < 200) begin
      @(negedge CLK);
      n++;
    end
  endtask

  task automatic t_reset();
    rd(RCP_OFS_CONFIG, d, r);
    `CHK("config reset", 32'h0000_0020, d)
    `CHK("pwrdn reset", 1'b1, PLL_PWRDN)
    `CHK("pll reset_n", 1'b0, PLL_RESET_N)
    `CHK("clock src", 1'b0, SYSTEM_CLOCK_FROM_PLL)
    `CHK("rd resp ok", RCP_RESP_OKAY, r)
    // Writing a one to the lock bit must not show; mode stays bypassed
    wr(RCP_OFS_CONFIG, 32'h0000_0021, r);
    `CHK("wr resp ok", RCP_RESP_OKAY, r)
    rd(RCP_OFS_CONFIG, d, r);
    `CHK("lock bit ro", 32'h0000_0020, d)
  endtask

  // Every mode code, low range requested in all of them
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wr(RCP_OFS_CONFIG, {24'h0, m, 5'h10}, r);
      `CHK("ref source", (m[1] ? RCP_SRC_CRYSTAL_INPUT : (m[2] ? RCP_SRC_CMOS : RCP_SRC_DIFF)), REF_SOURCE)
      `CHK("pll enable", ~m[0], PLL_ENABLE)
      `CHK("pll pwrdn", m[0], PLL_PWRDN)
      `CHK("low range", ~m[0], PLL_LOW_RANGE)
    end
  endtask

  // Divider fields, including N of zero and both ends of the factor range
  task automatic t_mult();
    logic [15:0] c[4] = '{16'h4020, 16'h822c, 16'h3e24, 16'hca38};
    int n, q;
    for (int i = 0; i < 4; i++) begin
      // Every entry keeps mode 001, so the PLL stays bypassed while extreme factors are set
      wr(RCP_OFS_CONFIG, {16'h0, c[i]}, r);
      n = (c[i][13:9] == 5'h0) ? 32 : int'(c[i][13:9]);
      q = (4 * n * (c[i][14] ? 2 : 1)) >> (int'(c[i][3]) + int'(c[i][15]));
      `CHK("mult", q[8:0], PLL_MULT_QTR)
      `CHK("fb n", c[i][13:9], PLL_FB_DIV_N)
      `CHK("fb div2", c[i][14], PLL_FB_DIV2)
      `CHK("in div2", c[i][3], PLL_IN_DIV2)
      `CHK("osc sel", c[i][2], PLL_OSC_SEL)
      `CHK("out div", c[i][15], PLL_OUT_DIV_EN)
    end
  endtask

  // Lock, interrupt, loss of lock, relock, then PLL reset
  task automatic t_lock();
    lock_dly <= 20;
    wr(RCP_OFS_IRQ_MASK, 32'h3, r);
    // Feedback N of one runs the PLL at unity, so the system clock never tops the limit
    wr(RCP_OFS_CONFIG, 32'h0202, r);
    `CHK("unlocked src", 1'b0, SYSTEM_CLOCK_FROM_PLL)
    `CHK("reset_n on", 1'b1, PLL_RESET_N)
    wait_sel(1'b1);
    `CHK("locked src", 1'b1, SYSTEM_CLOCK_FROM_PLL)
    rd(RCP_OFS_CONFIG, d, r);
    `CHK("lock bit", 32'h0203, d)
    rd(RCP_OFS_STATUS, d, r);
    `CHK("status", 32'h0013, d)
    `CHK("irq gained", 1'b1, IRQ)
    wr(RCP_OFS_IRQ_STATUS, 32'h1, r);
    `CHK("irq cleared", 1'b0, IRQ)
    drop <= 1'b1;
    wait_sel(1'b0);
    `CHK("lost src", 1'b0, SYSTEM_CLOCK_FROM_PLL)
    repeat (3) @(negedge CLK);
    rd(RCP_OFS_IRQ_STATUS, d, r);
    `CHK("irq status", 32'h2, d)
    wr(RCP_OFS_IRQ_MASK, 32'h1, r);
    `CHK("irq masked", 1'b0, IRQ)
    wr(RCP_OFS_IRQ_STATUS, 32'h2, r);
    lock_dly <= 60;
    drop <= 1'b0;
    wait_sel(1'b1);
    `CHK("relock src", 1'b1, SYSTEM_CLOCK_FROM_PLL)
    wr(RCP_OFS_CONFIG, 32'h0000, r);
    `CHK("reset_n off", 1'b0, PLL_RESET_N)
    wait_sel(1'b0);
    `CHK("held src", 1'b0, SYSTEM_CLOCK_FROM_PLL)
  endtask

  task automatic t_unmapped();
    wr(8'h20, 32'hffff_ffff, r);
    `CHK("wr resp", RCP_RESP_SLVERR, r)
    rd(8'h20, d, r);
    `CHK("rd resp", RCP_RESP_SLVERR, r)
    `CHK("rd data", 32'h0, d)
  endtask

  initial begin
    RESET = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, drop} = '0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'hf;
    lock_dly = 20;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_modes();
    t_mult();
    t_lock();
    t_unmapped();
    results();
  end
endmodule
